//--- rtl/m3pc_pkg.sv
package m3pc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] BUCK_KEY_ADDR = 8'h2F;
  localparam logic [7:0] RAIL_EN_ADDR = 8'h30;

  // Reset values: reserved 0, key action 1, offset 0, buck code 01100
  localparam logic [7:0] BUCK_KEY_RESET = 8'h4C;
  // Reset values: keep-alive code 0100, all four enables 1
  localparam logic [7:0] RAIL_EN_RESET = 8'h4F;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions, first register
  // ----------------------------------------------------------------------
  localparam int RSVD_BIT = 7;
  localparam int ON_KEY_ACTION_BIT = 6;
  localparam int SYS_BUCK_OFFSET_BIT = 5;
  localparam int SYS_BUCK_CODE_MSB = 4;
  localparam int SYS_BUCK_CODE_LSB = 0;
  localparam int SYS_BUCK_CODE_W = 5;

  // ----------------------------------------------------------------------
  // Field positions, second register
  // ----------------------------------------------------------------------
  localparam int KEEPALIVE_CODE_MSB = 7;
  localparam int KEEPALIVE_CODE_LSB = 4;
  localparam int KEEPALIVE_CODE_W = 4;
  localparam int CORE_BUCK_EN_BIT = 3;
  localparam int SYS_BUCK_EN_BIT = 2;
  localparam int KEEPALIVE_EN_BIT = 1;
  localparam int SYS_REG_EN_BIT = 0;

  // ----------------------------------------------------------------------
  // Voltage mapping, in millivolts
  // ----------------------------------------------------------------------
  localparam int MV_W = 12;
  localparam int STEP_MV = 25;
  localparam int SYS_BUCK_BASE_MV = 1500;
  localparam int SYS_BUCK_MAX_CODE = 24;
  localparam int SYS_BUCK_OFFSET_MV = 1200;
  localparam int KEEPALIVE_BASE_MV = 1700;
  localparam int KEEPALIVE_MAX_CODE = 8;

  // Key action encodings
  localparam logic ON_KEY_TO_MODE0 = 1'b0;
  localparam logic ON_KEY_STAY = 1'b1;

  // ----------------------------------------------------------------------
  // Mode settings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    M3PC_MODE0,
    M3PC_MODE1,
    M3PC_MODE2,
    M3PC_MODE3
  } m3pc_mode_type;

  // Two select bits to a mode setting
  function automatic m3pc_mode_type m3pc_to_mode(input logic [1:0] sel);
    m3pc_mode_type m;
    m = M3PC_MODE0;
    unique case (sel)
      2'h0: m = M3PC_MODE0;
      2'h1: m = M3PC_MODE1;
      2'h2: m = M3PC_MODE2;
      2'h3: m = M3PC_MODE3;
    endcase
    return m;
  endfunction : m3pc_to_mode

endpackage : m3pc_pkg

//--- rtl/m3pc_code_to_mv.sv
`timescale 1ns/1ps

// Saturating voltage-code decoder: clamps a code and turns it into mV
module m3pc_code_to_mv #(
  parameter int CODE_W = 5,
  parameter int MAX_CODE = 24,
  parameter int BASE_MV = 1500,
  parameter int ADD_MV = 1200
) (
  // Code in
  input wire logic [CODE_W-1:0] i_code,
  input wire logic i_add,
  // Decoded result
  output logic [CODE_W-1:0] o_code,
  output logic [m3pc_pkg::MV_W-1:0] o_mv
);

  localparam logic [CODE_W-1:0] MAX_C = CODE_W'(MAX_CODE);

  // Codes past the top step hold the top voltage
  always_comb
  begin
    o_code = (i_code > MAX_C) ? MAX_C : i_code;
    o_mv = m3pc_pkg::MV_W'(BASE_MV) + m3pc_pkg::MV_W'(o_code) * m3pc_pkg::MV_W'(m3pc_pkg::STEP_MV);
    if (i_add)
    begin
      o_mv = o_mv + m3pc_pkg::MV_W'(ADD_MV);
    end
  end

endmodule : m3pc_code_to_mv

//--- rtl/m3pc_regs.sv
// Operation
// R01 - Key fall with action 0 returns to mode 0
// R02 - Key fall with action 1 keeps mode
// R03 - Offset bit adds 1.2 V to buck
// R04 - Buck code 1.500 V, 25 mV steps, saturates
// R05 - Keep-alive code 1.700 V, 25 mV steps, saturates
// R06 - Bit 3 enables core buck
// R07 - Bit 2 enables system buck
// R08 - Bit 1 enables keep-alive regulator
// R09 - Bit 0 enables system regulator
// R10 - Both registers read back last written value
// R11 - Mode from pins or register bits, per select
// R12 - Fields act only while mode 3 active
// R13 - Reserved bit stores and reads, no effect
`timescale 1ns/1ps

module m3pc_regs (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [m3pc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [m3pc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [m3pc_pkg::DATA_W-1:0] o_rdata,
  // Mode selection sources
  input wire logic i_mode3_pin_select_source,
  input wire logic [1:0] i_mode_select_pins,
  input wire logic i_mode_select_bit0,
  input wire logic i_mode_select_bit1,
  // Debounced key event
  input wire logic i_on_fall,
  // Mode status
  output logic [1:0] o_active_mode,
  output logic o_mode3_active,
  output logic o_return_to_mode0,
  // Rail controls for mode setting 3
  output logic o_core_buck_en,
  output logic o_system_buck_en,
  output logic o_keepalive_reg_en,
  output logic o_system_reg_en,
  output logic [4:0] o_system_buck_code,
  output logic o_system_buck_offset,
  output logic [m3pc_pkg::MV_W-1:0] o_system_buck_mv,
  output logic [3:0] o_keepalive_reg_code,
  output logic [m3pc_pkg::MV_W-1:0] o_keepalive_reg_mv
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------

  // Shared by the write path and the read path
  function automatic logic m3pc_hit(
    input logic [m3pc_pkg::ADDR_W-1:0] addr,
    input logic [m3pc_pkg::ADDR_W-1:0] reg_addr
  );
    return addr == reg_addr;
  endfunction : m3pc_hit

  logic buck_key_hit;
  logic rail_en_hit;

  // Each register decoded once from the raw address
  assign buck_key_hit = m3pc_hit(i_addr, m3pc_pkg::BUCK_KEY_ADDR);
  assign rail_en_hit = m3pc_hit(i_addr, m3pc_pkg::RAIL_EN_ADDR);

  // ----------------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------------

  logic [m3pc_pkg::DATA_W-1:0] buck_key_q;
  logic [m3pc_pkg::DATA_W-1:0] rail_en_q;

  // First register: all eight bits stored, reserved bit too
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      buck_key_q <= m3pc_pkg::BUCK_KEY_RESET;
    end
    else if (i_wr && buck_key_hit)
    begin
      buck_key_q <= i_wdata; // R10 R13
    end
  end

  // Second register: keep-alive code and four rail enables
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      rail_en_q <= m3pc_pkg::RAIL_EN_RESET;
    end
    else if (i_wr && rail_en_hit)
    begin
      rail_en_q <= i_wdata; // R10
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------

  logic [m3pc_pkg::DATA_W-1:0] rdata_d;
  logic [m3pc_pkg::DATA_W-1:0] rdata_q;

  // Stored values come back unaltered; unmapped addresses read zero
  always_comb
  begin
    rdata_d = m3pc_pkg::READ_IDLE;
    if (i_rd && buck_key_hit)
    begin
      rdata_d = buck_key_q; // R10 R13
    end
    else if (i_rd && rail_en_hit)
    begin
      rdata_d = rail_en_q; // R10
    end
  end

  // Data stand for exactly the cycle after the strobe, zero otherwise
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      rdata_q <= m3pc_pkg::READ_IDLE;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------------

  logic on_key_action;
  logic sys_buck_offset;
  logic [m3pc_pkg::SYS_BUCK_CODE_W-1:0] sys_buck_code_raw;
  logic [m3pc_pkg::KEEPALIVE_CODE_W-1:0] keepalive_code_raw;

  // The reserved bit is deliberately not picked up anywhere
  assign on_key_action = buck_key_q[m3pc_pkg::ON_KEY_ACTION_BIT];
  assign sys_buck_offset = buck_key_q[m3pc_pkg::SYS_BUCK_OFFSET_BIT];
  assign sys_buck_code_raw = buck_key_q[m3pc_pkg::SYS_BUCK_CODE_MSB:m3pc_pkg::SYS_BUCK_CODE_LSB];
  assign keepalive_code_raw =
    rail_en_q[m3pc_pkg::KEEPALIVE_CODE_MSB:m3pc_pkg::KEEPALIVE_CODE_LSB];

  // ----------------------------------------------------------------------
  // Code decoders
  // ----------------------------------------------------------------------

  logic [m3pc_pkg::SYS_BUCK_CODE_W-1:0] sys_buck_code_sat;
  logic [m3pc_pkg::MV_W-1:0] sys_buck_mv;
  logic [m3pc_pkg::KEEPALIVE_CODE_W-1:0] keepalive_code_sat;
  logic [m3pc_pkg::MV_W-1:0] keepalive_mv;

  // System buck: 1.500 V base, clamp above 11000, optional 1.2 V offset
  m3pc_code_to_mv #(
    .CODE_W(m3pc_pkg::SYS_BUCK_CODE_W),
    .MAX_CODE(m3pc_pkg::SYS_BUCK_MAX_CODE),
    .BASE_MV(m3pc_pkg::SYS_BUCK_BASE_MV),
    .ADD_MV(m3pc_pkg::SYS_BUCK_OFFSET_MV)
  ) u_sys_buck_dec (
    .i_code(sys_buck_code_raw), // R04
    .i_add(sys_buck_offset), // R03
    .o_code(sys_buck_code_sat),
    .o_mv(sys_buck_mv)
  );

  // Keep-alive regulator: 1.700 V base, clamp above 1000, no offset
  m3pc_code_to_mv #(
    .CODE_W(m3pc_pkg::KEEPALIVE_CODE_W),
    .MAX_CODE(m3pc_pkg::KEEPALIVE_MAX_CODE),
    .BASE_MV(m3pc_pkg::KEEPALIVE_BASE_MV),
    .ADD_MV(0)
  ) u_keepalive_dec (
    .i_code(keepalive_code_raw), // R05
    .i_add(1'b0),
    .o_code(keepalive_code_sat),
    .o_mv(keepalive_mv)
  );

  // ----------------------------------------------------------------------
  // Active mode selection
  // ----------------------------------------------------------------------

  m3pc_pkg::m3pc_mode_type mode_d;
  m3pc_pkg::m3pc_mode_type mode_q;
  logic mode3_now;

  // One source only: the other is ignored entirely, never merged
  always_comb
  begin
    if (i_mode3_pin_select_source)
    begin
      mode_d = m3pc_pkg::m3pc_to_mode(i_mode_select_pins); // R11
    end
    else
    begin
      mode_d = m3pc_pkg::m3pc_to_mode({i_mode_select_bit1, i_mode_select_bit0}); // R11
    end
  end

  // Mode registered so every control below switches in the same cycle
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      mode_q <= m3pc_pkg::M3PC_MODE0;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  assign mode3_now = (mode_d == m3pc_pkg::M3PC_MODE3);
  assign o_active_mode = mode_q;

  // ----------------------------------------------------------------------
  // Mode status flag
  // ----------------------------------------------------------------------

  logic mode3_q;

  // Qualifies the rail controls; downstream selects them only when high
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      mode3_q <= 1'b0;
    end
    else
    begin
      mode3_q <= mode3_now; // R12
    end
  end

  assign o_mode3_active = mode3_q;

  // ----------------------------------------------------------------------
  // Key event handling
  // ----------------------------------------------------------------------

  logic return_q;

  // Only a request; the mode logic outside performs the switch.
  // Action 1 swallows the event, and mode 0 never asks to re-enter itself.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      return_q <= 1'b0;
    end
    else
    begin
      return_q <= i_on_fall && mode3_now &&
                  (mode_d != m3pc_pkg::M3PC_MODE0) &&
                  (on_key_action == m3pc_pkg::ON_KEY_TO_MODE0); // R01 R02 R12
    end
  end

  assign o_return_to_mode0 = return_q;

  // ----------------------------------------------------------------------
  // Rail enables
  // ----------------------------------------------------------------------

  logic core_buck_en_q;
  logic sys_buck_en_q;
  logic keepalive_en_q;
  logic sys_reg_en_q;

  // Outside mode 3 the stored bits are held but drive nothing
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      core_buck_en_q <= 1'b0;
      sys_buck_en_q <= 1'b0;
      keepalive_en_q <= 1'b0;
      sys_reg_en_q <= 1'b0;
    end
    else
    begin
      core_buck_en_q <= mode3_now && rail_en_q[m3pc_pkg::CORE_BUCK_EN_BIT]; // R06 R12
      sys_buck_en_q <= mode3_now && rail_en_q[m3pc_pkg::SYS_BUCK_EN_BIT]; // R07 R12
      keepalive_en_q <= mode3_now && rail_en_q[m3pc_pkg::KEEPALIVE_EN_BIT]; // R08 R12
      sys_reg_en_q <= mode3_now && rail_en_q[m3pc_pkg::SYS_REG_EN_BIT]; // R09 R12
    end
  end

  assign o_core_buck_en = core_buck_en_q;
  assign o_system_buck_en = sys_buck_en_q;
  assign o_keepalive_reg_en = keepalive_en_q;
  assign o_system_reg_en = sys_reg_en_q;

  // ----------------------------------------------------------------------
  // Voltage targets
  // ----------------------------------------------------------------------

  logic [m3pc_pkg::SYS_BUCK_CODE_W-1:0] sys_buck_code_q;
  logic sys_buck_offset_q;
  logic [m3pc_pkg::MV_W-1:0] sys_buck_mv_q;
  logic [m3pc_pkg::KEEPALIVE_CODE_W-1:0] keepalive_code_q;
  logic [m3pc_pkg::MV_W-1:0] keepalive_mv_q;

  // Zero outside mode 3 so a stale target cannot leak into another mode
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sys_buck_code_q <= '0;
      sys_buck_offset_q <= 1'b0;
      sys_buck_mv_q <= '0;
      keepalive_code_q <= '0;
      keepalive_mv_q <= '0;
    end
    else if (mode3_now)
    begin
      sys_buck_code_q <= sys_buck_code_sat; // R04 R12
      sys_buck_offset_q <= sys_buck_offset; // R03 R12
      sys_buck_mv_q <= sys_buck_mv; // R03 R04
      keepalive_code_q <= keepalive_code_sat; // R05 R12
      keepalive_mv_q <= keepalive_mv; // R05
    end
    else
    begin
      sys_buck_code_q <= '0;
      sys_buck_offset_q <= 1'b0;
      sys_buck_mv_q <= '0;
      keepalive_code_q <= '0;
      keepalive_mv_q <= '0;
    end
  end

  assign o_system_buck_code = sys_buck_code_q;
  assign o_system_buck_offset = sys_buck_offset_q;
  assign o_system_buck_mv = sys_buck_mv_q;
  assign o_keepalive_reg_code = keepalive_code_q;
  assign o_keepalive_reg_mv = keepalive_mv_q;

endmodule : m3pc_regs

//--- dv/m3pc_regs_assertions.sv
`timescale 1ns/1ps

// ---------------------------------------------
// Port checker for the mode 3 register bank
// ---------------------------------------------
module m3pc_regs_chk (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Mode sources and status
  input wire logic i_mode3_pin_select_source,
  input wire logic [1:0] i_mode_select_pins,
  input wire logic i_mode_select_bit0,
  input wire logic i_mode_select_bit1,
  input wire logic i_on_fall,
  input wire logic [1:0] o_active_mode,
  input wire logic o_mode3_active,
  input wire logic o_return_to_mode0,
  // Rail controls
  input wire logic o_core_buck_en,
  input wire logic o_system_buck_en,
  input wire logic o_keepalive_reg_en,
  input wire logic o_system_reg_en,
  input wire logic [4:0] o_system_buck_code,
  input wire logic o_system_buck_offset,
  input wire logic [11:0] o_system_buck_mv,
  input wire logic [3:0] o_keepalive_reg_code,
  input wire logic [11:0] o_keepalive_reg_mv
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // Enables gathered so one compare covers all four rails
  logic [3:0] en;
  assign en = {o_core_buck_en, o_system_buck_en, o_keepalive_reg_en, o_system_reg_en};

  rd_idle_a:
    assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data out of slot");
  unmapped_rd_a:
    assert property (i_rd && i_addr != 8'h2f && i_addr != 8'h30 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  mode_source_a:
    assert property (!$past(i_rst) |-> o_active_mode == ($past(i_mode3_pin_select_source) ?
      $past(i_mode_select_pins) : {$past(i_mode_select_bit1), $past(i_mode_select_bit0)}))
    else $error("active mode from wrong source");
  mode3_flag_a:
    assert property (o_mode3_active == (o_active_mode == 2'h3)) else $error("mode 3 flag wrong");
  rails_off_a:
    assert property (!o_mode3_active |-> en == 4'h0 && o_system_buck_code == 5'h00 &&
      !o_system_buck_offset && o_system_buck_mv == 12'h000 && o_keepalive_reg_code == 4'h0 &&
      o_keepalive_reg_mv == 12'h000) else $error("rail output outside mode 3");
  buck_volt_a:
    assert property (o_mode3_active |-> o_system_buck_code <= 5'h18 && o_system_buck_mv ==
      1500 + 25 * o_system_buck_code + (o_system_buck_offset ? 1200 : 0))
    else $error("buck millivolts wrong");
  keep_volt_a:
    assert property (o_mode3_active |-> o_keepalive_reg_code <= 4'h8 &&
      o_keepalive_reg_mv == 1700 + 25 * o_keepalive_reg_code) else $error("keep-alive mv wrong");
  key_cause_a:
    assert property (o_return_to_mode0 |-> $past(i_on_fall) && o_mode3_active)
    else $error("return pulse without cause");
  rail_write_a:
    assert property (i_wr && i_addr == 8'h30 ##2 o_mode3_active |-> en == $past(i_wdata[3:0], 2))
    else $error("enables do not follow write");

  // Main scenarios reached
  cover property (o_return_to_mode0);
  cover property (o_mode3_active && o_system_buck_offset);
  cover property ($past(i_rd) && o_rdata != 8'h00);
endmodule : m3pc_regs_chk

bind m3pc_regs m3pc_regs_chk i_chk (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_mode3_pin_select_source, .i_mode_select_pins, .i_mode_select_bit0,
  .i_mode_select_bit1, .i_on_fall, .o_active_mode, .o_mode3_active, .o_return_to_mode0,
  .o_core_buck_en, .o_system_buck_en, .o_keepalive_reg_en, .o_system_reg_en,
  .o_system_buck_code, .o_system_buck_offset, .o_system_buck_mv, .o_keepalive_reg_code,
  .o_keepalive_reg_mv);

//--- dv/m3pc_host.sv
`timescale 1ns/1ps

// ---------------------------------------------
// Host model driving the register port
// ---------------------------------------------
module m3pc_host (
  // Clock
  input wire logic i_sys_clk,
  // Register port
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [7:0] i_rdata
);
  // Bus idle at time zero
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One-cycle write; data flips afterwards so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask : wr

  // One-cycle read; data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask : rd
endmodule : m3pc_host

//--- dv/m3pc_regs_tb.sv
`timescale 1ns/1ps

// ---------------------------------------------
// Self-checking bench for the mode 3 bank
// ---------------------------------------------
module m3pc_regs_tb;
  logic i_sys_clk, i_rst, i_wr, i_rd, i_on_fall, o_mode3_active, o_return_to_mode0;
  logic [7:0] i_addr, i_wdata, o_rdata, d;
  logic i_mode3_pin_select_source, i_mode_select_bit0, i_mode_select_bit1;
  logic [1:0] i_mode_select_pins, o_active_mode;
  logic o_core_buck_en, o_system_buck_en, o_keepalive_reg_en, o_system_reg_en;
  logic o_system_buck_offset;
  logic [4:0] o_system_buck_code;
  logic [3:0] o_keepalive_reg_code;
  logic [11:0] o_system_buck_mv, o_keepalive_reg_mv;
  int errors, tests_run, cs, kc;

  m3pc_regs i_dut (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_mode3_pin_select_source, .i_mode_select_pins, .i_mode_select_bit0,
    .i_mode_select_bit1, .i_on_fall, .o_active_mode, .o_mode3_active, .o_return_to_mode0,
    .o_core_buck_en, .o_system_buck_en, .o_keepalive_reg_en, .o_system_reg_en,
    .o_system_buck_code, .o_system_buck_offset, .o_system_buck_mv, .o_keepalive_reg_code,
    .o_keepalive_reg_mv);
  m3pc_host i_host (.i_sys_clk, .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
    .o_rd(i_rd), .i_rdata(o_rdata));

  // 100 MHz clock
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // Waits n edges and lets their updates land
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : step

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk("rdata", {4'h0, e}, {4'h0, d});
  endtask : rdchk

  // The unused source is driven to the opposite value so a wrong pick shows
  task automatic set_mode(input logic s, input logic [1:0] m);
    @(posedge i_sys_clk);
    i_mode3_pin_select_source <= s;
    i_mode_select_pins <= s ? m : ~m;
    {i_mode_select_bit1, i_mode_select_bit0} <= s ? ~m : m;
    step(2);
  endtask : set_mode

  task automatic fire(input logic e);
    @(posedge i_sys_clk);
    i_on_fall <= 1'b1;
    @(posedge i_sys_clk);
    i_on_fall <= 1'b0;
    #1;
    chk("return", {11'h0, e}, {11'h0, o_return_to_mode0});
    step(1);
    chk("return end", 12'h000, {11'h0, o_return_to_mode0});
  endtask : fire

  task automatic t_reset();
    rdchk(8'h2f, 8'h4c);
    rdchk(8'h30, 8'h4f);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_rw();
    i_host.wr(8'h2f, 8'ha5);
    i_host.wr(8'h30, 8'h5a);
    i_host.wr(8'h31, 8'hff);
    rdchk(8'h2f, 8'ha5);
    rdchk(8'h30, 8'h5a);
    rdchk(8'h31, 8'h00);
    step(1);
    chk("rdata idle", 12'h000, {4'h0, o_rdata});
    $display("test read write done");
  endtask : t_rw

  task automatic t_mode();
    for (int m = 0; m < 4; m++)
    begin
      for (int s = 0; s < 2; s++)
      begin
        set_mode(s[0], m[1:0]);
        chk("mode", 12'(m), {10'h0, o_active_mode});
        chk("mode3", 12'(m == 3), {11'h0, o_mode3_active});
      end
    end
    $display("test mode select done");
  endtask : t_mode

  task automatic t_enables();
    set_mode(1'b1, 2'h3);
    for (int i = 0; i < 4; i++)
    begin
      i_host.wr(8'h30, 8'h40 | 8'(1 << i));
      step(2);
      chk("enables", 12'(1 << i), {8'h0, o_core_buck_en, o_system_buck_en,
        o_keepalive_reg_en, o_system_reg_en});
    end
    // All four bits set first, so a leak outside mode 3 cannot hide
    i_host.wr(8'h30, 8'h4f);
    set_mode(1'b0, 2'h2);
    chk("enables off", 12'h000, {8'h0, o_core_buck_en, o_system_buck_en,
      o_keepalive_reg_en, o_system_reg_en});
    $display("test enables done");
  endtask : t_enables

  // Every code of both fields, offset toggling, past the saturation point
  task automatic t_codes();
    set_mode(1'b1, 2'h3);
    for (int c = 0; c < 32; c++)
    begin
      i_host.wr(8'h2f, {2'b01, c[0], c[4:0]});
      i_host.wr(8'h30, {c[3:0], 4'hf});
      step(2);
      cs = (c > 24) ? 24 : c;
      kc = (c[3:0] > 8) ? 8 : int'(c[3:0]);
      chk("buck code", 12'(cs), {7'h0, o_system_buck_code});
      chk("buck mv", 12'(1500 + 25 * cs + (c[0] ? 1200 : 0)), o_system_buck_mv);
      chk("buck offset", 12'(c[0]), {11'h0, o_system_buck_offset});
      chk("keep code", 12'(kc), {8'h0, o_keepalive_reg_code});
      chk("keep mv", 12'(1700 + 25 * kc), o_keepalive_reg_mv);
    end
    $display("test voltage codes done");
  endtask : t_codes

  task automatic t_key();
    i_host.wr(8'h2f, 8'h0c);
    fire(1'b1);
    set_mode(1'b0, 2'h0);
    fire(1'b0);
    // Action 0 must stay silent in another mode as well
    set_mode(1'b1, 2'h1);
    fire(1'b0);
    set_mode(1'b1, 2'h3);
    i_host.wr(8'h2f, 8'h4c);
    fire(1'b0);
    $display("test key action done");
  endtask : t_key

  // Reset in mid-run: stored values and rail outputs fall back to defaults
  task automatic t_rst_mid();
    i_host.wr(8'h2f, 8'hb3);
    i_host.wr(8'h30, 8'h90);
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    step(2);
    chk("reset mode3", 12'h000, {11'h0, o_mode3_active});
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    step(2);
    chk("reset enables", 12'h00f, {8'h0, o_core_buck_en, o_system_buck_en,
      o_keepalive_reg_en, o_system_reg_en});
    chk("reset buck mv", 12'h708, o_system_buck_mv);
    chk("reset keep mv", 12'h708, o_keepalive_reg_mv);
    rdchk(8'h2f, 8'h4c);
    rdchk(8'h30, 8'h4f);
    $display("test mid-run reset done");
  endtask : t_rst_mid

  // Main sequence
  initial
  begin
    errors = 0;
    tests_run = 0;
    i_rst = 1'b1;
    i_on_fall = 1'b0;
    i_mode3_pin_select_source = 1'b0;
    i_mode_select_pins = 2'h0;
    i_mode_select_bit0 = 1'b0;
    i_mode_select_bit1 = 1'b0;
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    step(1);
    t_reset();
    t_rw();
    t_mode();
    t_enables();
    t_codes();
    t_key();
    t_rst_mid();
    give_verdict();
  end

  // Watchdog: the tests need a few hundred cycles at most
  initial
  begin
    #200us;
    errors++;
    give_verdict();
  end
endmodule : m3pc_regs_tb
